// file: design/fod_pkg.sv
// package: offsets, field positions, reset values for the override bank
package fod_pkg;
	// register indices; byte address is four times the index
	localparam logic [7:0] IDX_FORCE_CHG = 8'h1E;
	localparam logic [7:0] IDX_RATE      = 8'h1F;
	localparam logic [7:0] IDX_SER1_FIFO = 8'h20;
	localparam logic [7:0] IDX_SER2_FIFO = 8'h21;
	localparam logic [7:0] IDX_UNIT_DIS  = 8'h22;

	// reset values
	localparam logic [7:0] FORCE_CHG_RST = 8'h03;
	localparam logic [7:0] UNIT_DIS_RST  = 8'h00;

	// force disk change fields
	localparam int unsigned FC_DRV0 = 0;
	localparam int unsigned FC_DRV1 = 1;
	localparam int unsigned NUM_DRV = 2;

	// unit disable fields
	localparam int unsigned DIS_WP_BIT   = 0;
	localparam int unsigned DIS_UNIT_LSB = 3;
	localparam int unsigned NUM_UNITS    = 5;
	// unit order inside the unit vectors (bit 3 upward of unit_disable)
	localparam int unsigned UNIT_FLOPPY  = 0;
	localparam int unsigned UNIT_MIDI    = 1;
	localparam int unsigned UNIT_SER2    = 2;
	localparam int unsigned UNIT_SER1    = 3;
	localparam int unsigned UNIT_PAR     = 4;

	// read masks: reserved bits read as zero
	localparam logic [7:0] FORCE_CHG_MASK = 8'h03;
	localparam logic [7:0] RATE_MASK      = 8'hDF;
	localparam logic [7:0] FIFO_MASK      = 8'hCF;
	localparam logic [7:0] UNIT_DIS_MASK  = 8'hF9;

	// lock pin configuration code that makes unit_disable read-only
	localparam logic [1:0] LOCK_RO_CODE = 2'b01;

	// bus widths
	localparam int unsigned WB_DW = 32;
	localparam int unsigned WB_SW = 4;
endpackage : fod_pkg

// file: design/fod_ovr_if.sv
// interface: control bank to override logic
`timescale 1ns/1ps
interface fod_ovr_if;
	import fod_pkg::*;
	logic                 sel0;
	logic                 sel1;
	logic [NUM_DRV-1:0]   force_chg;
	logic                 wp_force_all;
	logic [NUM_UNITS-1:0] unit_off;
	logic                 force_wp_cfg;
	logic                 wp_ext_n;
	logic                 chg_in_n;
	logic [NUM_UNITS-1:0] activate;
	logic                 disk_chg;
	logic                 wp_core_n;
	logic [NUM_UNITS-1:0] enable;

	modport ctl (
		output sel0, sel1, force_chg, wp_force_all, unit_off,
		output force_wp_cfg, wp_ext_n, chg_in_n, activate,
		input  disk_chg, wp_core_n, enable
	);
	modport ovr (
		input  sel0, sel1, force_chg, wp_force_all, unit_off,
		input  force_wp_cfg, wp_ext_n, chg_in_n, activate,
		output disk_chg, wp_core_n, enable
	);
endinterface : fod_ovr_if

// file: design/fod_override.sv
// module: disk change, write protect and unit enable overrides
`timescale 1ns/1ps
module fod_override (
	input wire logic sys_clk,
	input wire logic reset,
	fod_ovr_if.ovr   ov
);
	import fod_pkg::*;

	typedef struct packed {
		logic                 disk_chg;
		logic                 wp_core_n;
		logic [NUM_UNITS-1:0] enable;
	} fod_ovr_state_t;

	fod_ovr_state_t s_q;
	fod_ovr_state_t s_d;
	logic [NUM_UNITS-1:0] en_w;

	// a set disable bit wins over the unit's own activate bit
	genvar gi;
	generate
		for (gi = 0; gi < NUM_UNITS; gi++) begin : g_unit
			assign en_w[gi] = ov.activate[gi] & ~ov.unit_off[gi];
		end
	endgenerate

	// outputs registered so the floppy core sees clean levels
	always_comb begin
		s_d = s_q;
		if (reset) begin
			s_d.disk_chg  = 1'b0;
			s_d.wp_core_n = 1'b1;
			s_d.enable    = '0;
		end else begin
			s_d.disk_chg = (ov.sel0 & ov.force_chg[FC_DRV0])
				| (ov.sel1 & ov.force_chg[FC_DRV1])
				| ~ov.chg_in_n;
			// active low toward the core; disable bit forces protect
			s_d.wp_core_n = ~((ov.sel0 & ov.force_wp_cfg)
				| (ov.sel1 & ov.force_wp_cfg)
				| ~ov.wp_ext_n
				| ov.wp_force_all);
			s_d.enable = en_w;
		end
	end

	always_ff @(posedge sys_clk) begin
		s_q <= s_d;
	end

	assign ov.disk_chg  = s_q.disk_chg;
	assign ov.wp_core_n = s_q.wp_core_n;
	assign ov.enable    = s_q.enable;
endmodule : fod_override

// file: design/fod_bank.sv
// module: force disk change, shadows and unit disable register bank
//
// Register access over Wishbone was chosen for this implementation.
`timescale 1ns/1ps
// How it works
// - writing 1 sets drive flag; 0 ignored
// - step with select 0 clears flag 0
// - step with select 1 clears flag 1
// - disk change from flags, selects, input
// - flags load 03 on main reset
// - read-only mirror of floppy rate control
// - read-only mirror of serial one fifo
// - read-only mirror of serial two fifo
// - disable bit overrides unit activate bit
// - disable bit 0 forces write protect
// - write protect from selects, cfg, pin, bit0
// - forced protect bit comes from config input
// - disable bits 2:1 read zero
// - bits 7:3 map floppy, midi, ser2, ser1, par
module fod_bank #(
	parameter int unsigned ADR_W = 10
) (
	input  wire logic                          sys_clk,
	input  wire logic                          reset,
	input  wire logic                          standby_power_on_reset,
	input  wire logic                          wb_cyc_i,
	input  wire logic                          wb_stb_i,
	input  wire logic                          wb_we_i,
	input  wire logic [ADR_W-1:0]              wb_adr_i,
	input  wire logic [fod_pkg::WB_SW-1:0]     wb_sel_i,
	input  wire logic [fod_pkg::WB_DW-1:0]     wb_dat_i,
	output      logic [fod_pkg::WB_DW-1:0]     wb_dat_o,
	output      logic                          wb_ack_o,
	input  wire logic                          step_pulse_n,
	input  wire logic                          drive_select0_n,
	input  wire logic                          drive_select1_n,
	input  wire logic                          disk_change_in_n,
	input  wire logic                          write_protect_n,
	input  wire logic                          force_wp_cfg,
	input  wire logic [1:0]                    lock_cfg,
	input  wire logic                          lock_gpio_pin,
	input  wire logic [7:0]                    floppy_rate_in,
	input  wire logic [7:0]                    serial_one_fifo_in,
	input  wire logic [7:0]                    serial_two_fifo_in,
	input  wire logic [fod_pkg::NUM_UNITS-1:0] unit_activate,
	output      logic [fod_pkg::NUM_UNITS-1:0] unit_enable,
	output      logic                          disk_change_flag,
	output      logic                          write_protect_core_n,
	output      logic [fod_pkg::NUM_DRV-1:0]   force_change,
	output      logic                          unit_disable_locked
);
	import fod_pkg::*;

	////////////////////////////////////////////////////////////////////
	// state

	typedef struct packed {
		logic [NUM_DRV-1:0] force_chg;
		logic [7:0]         unit_dis;
		logic               step_n;
		logic               ack;
		logic [7:0]         rdata;
	} fod_bank_state_t;

	fod_bank_state_t s_q;
	fod_bank_state_t s_d;

	////////////////////////////////////////////////////////////////////
	// decode helpers

	// true when the word address selects the given register index
	function automatic logic reg_hit(
		input logic [ADR_W-1:0] adr,
		input logic [7:0]       idx
	);
		logic [ADR_W-3:0] word;
		word = adr[ADR_W-1:2];
		reg_hit = (word == (ADR_W-2)'(idx));
	endfunction : reg_hit

	// read value of one register; unmapped words read as zero
	function automatic logic [7:0] read_value(
		input logic [ADR_W-1:0] adr,
		input logic [1:0]       fc,
		input logic [7:0]       dis,
		input logic [7:0]       rate,
		input logic [7:0]       fifo1,
		input logic [7:0]       fifo2
	);
		logic [7:0] v;
		v = 8'h00;
		if (reg_hit(adr, IDX_FORCE_CHG)) begin
			v = {6'h00, fc} & FORCE_CHG_MASK;
		end else if (reg_hit(adr, IDX_RATE)) begin
			v = rate & RATE_MASK;
		end else if (reg_hit(adr, IDX_SER1_FIFO)) begin
			v = fifo1 & FIFO_MASK;
		end else if (reg_hit(adr, IDX_SER2_FIFO)) begin
			v = fifo2 & FIFO_MASK;
		end else if (reg_hit(adr, IDX_UNIT_DIS)) begin
			v = dis & UNIT_DIS_MASK;
		end
		read_value = v;
	endfunction : read_value

	////////////////////////////////////////////////////////////////////
	// bus qualifiers

	logic       req;
	logic       wr_lo;
	logic [7:0] wbyte;
	logic       wr_fc;
	logic       wr_dis;
	logic       locked;

	// one access per request: ack_q blocks a repeat while ack is high
	assign req   = wb_cyc_i & wb_stb_i & ~s_q.ack;
	assign wr_lo = req & wb_we_i & wb_sel_i[0];
	assign wbyte = wb_dat_i[7:0];

	// lock only bites when the pin is set up for it and held high
	assign locked = (lock_cfg == LOCK_RO_CODE) & lock_gpio_pin;

	assign wr_fc  = wr_lo & reg_hit(wb_adr_i, IDX_FORCE_CHG);
	assign wr_dis = wr_lo & reg_hit(wb_adr_i, IDX_UNIT_DIS) & ~locked;

	////////////////////////////////////////////////////////////////////
	// drive side terms

	logic               sel0;
	logic               sel1;
	logic               step_fall;
	logic [NUM_DRV-1:0] fc_set;
	logic [NUM_DRV-1:0] fc_clr;

	// selects are active low at the pins
	assign sel0 = ~drive_select0_n;
	assign sel1 = ~drive_select1_n;

	// edge of the step pulse so a long low step clears only once,
	// and a later software set is not wiped by the same pulse
	assign step_fall = s_q.step_n & ~step_pulse_n;

	// software can only set; zeros written are ignored
	assign fc_set = wr_fc ? wbyte[NUM_DRV-1:0] : '0;

	// hardware clears on a step toward the selected drive
	assign fc_clr[FC_DRV0] = step_fall & sel0;
	assign fc_clr[FC_DRV1] = step_fall & sel1;

	////////////////////////////////////////////////////////////////////
	// next state

	// set beats clear so a write landing on a step is not lost
	always_comb begin
		s_d = s_q;
		s_d.step_n = step_pulse_n;
		s_d.force_chg = (s_q.force_chg & ~fc_clr) | fc_set;
		if (wr_dis) begin
			s_d.unit_dis = wbyte & UNIT_DIS_MASK;
		end
		// ack high for exactly one cycle per request
		s_d.ack = req;
		if (req) begin
			s_d.rdata = read_value(wb_adr_i, s_q.force_chg,
				s_q.unit_dis, floppy_rate_in,
				serial_one_fifo_in, serial_two_fifo_in);
		end
		// main supply reset owns the flags and the bus handshake
		if (reset) begin
			s_d.force_chg = FORCE_CHG_RST[NUM_DRV-1:0];
			s_d.step_n    = 1'b1;
			s_d.ack       = 1'b0;
			s_d.rdata     = 8'h00;
		end
		// standby reset alone owns unit_disable, it survives a main
		// supply reset so disabled units stay off across it
		if (standby_power_on_reset) begin
			s_d.unit_dis = UNIT_DIS_RST;
		end
	end

	always_ff @(posedge sys_clk) begin
		s_q <= s_d;
	end

	////////////////////////////////////////////////////////////////////
	// override logic

	fod_ovr_if ovr_bus ();

	assign ovr_bus.sel0         = sel0;
	assign ovr_bus.sel1         = sel1;
	assign ovr_bus.force_chg    = s_q.force_chg;
	assign ovr_bus.wp_force_all = s_q.unit_dis[DIS_WP_BIT];
	assign ovr_bus.force_wp_cfg = force_wp_cfg;
	assign ovr_bus.wp_ext_n     = write_protect_n;
	assign ovr_bus.chg_in_n     = disk_change_in_n;
	assign ovr_bus.activate     = unit_activate;

	// bits 7:3 of unit_disable, floppy at bit 3 up to parallel at 7
	assign ovr_bus.unit_off =
		s_q.unit_dis[DIS_UNIT_LSB +: NUM_UNITS];

	fod_override u_override (
		.sys_clk (sys_clk),
		.reset   (reset),
		.ov      (ovr_bus)
	);

	////////////////////////////////////////////////////////////////////
	// outputs

	// read data only the low byte, upper lanes read zero
	assign wb_dat_o             = {{(WB_DW-8){1'b0}}, s_q.rdata};
	assign wb_ack_o             = s_q.ack;
	assign unit_enable          = ovr_bus.enable;
	assign disk_change_flag     = ovr_bus.disk_chg;
	assign write_protect_core_n = ovr_bus.wp_core_n;
	assign force_change         = s_q.force_chg;
	assign unit_disable_locked  = locked;
endmodule : fod_bank

// file: verif/fod_bank_props.sv
// checker: concurrent properties on the bank's ports
`timescale 1ns/1ps
module fod_bank_props (
	input wire logic       sys_clk,
	input wire logic       reset,
	input wire logic       wb_cyc_i,
	input wire logic       wb_stb_i,
	input wire logic       wb_we_i,
	input wire logic       wb_ack_o,
	input wire logic       step_pulse_n,
	input wire logic       drive_select0_n,
	input wire logic       drive_select1_n,
	input wire logic       disk_change_in_n,
	input wire logic       write_protect_n,
	input wire logic       force_wp_cfg,
	input wire logic [1:0] lock_cfg,
	input wire logic       lock_gpio_pin,
	input wire logic [4:0] unit_activate,
	input wire logic [4:0] unit_enable,
	input wire logic       disk_change_flag,
	input wire logic       write_protect_core_n,
	input wire logic [1:0] force_change,
	input wire logic       unit_disable_locked
);
	// one clock domain, main reset masks everything
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);
	AST_ACK: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
		|=> wb_ack_o ##1 !wb_ack_o) else $error("ack not one cycle");
	AST_FC_RST: assert property ($fell(reset) |-> force_change == 2'b11)
		else $error("flags not set after reset");
	AST_CLR0: assert property (!$past(reset) && $fell(step_pulse_n)
		&& !drive_select0_n && !(wb_cyc_i && wb_stb_i && wb_we_i)
		|=> !force_change[0]) else $error("flag 0 not cleared");
	AST_CLR1: assert property (!$past(reset) && $fell(step_pulse_n)
		&& !drive_select1_n && !(wb_cyc_i && wb_stb_i && wb_we_i)
		|=> !force_change[1]) else $error("flag 1 not cleared");
	// a set flag 0 only falls through a step on drive 0
	AST_HOLD: assert property (force_change[0] && !($fell(step_pulse_n)
		&& !drive_select0_n) |=> force_change[0]) else $error("flag 0 lost");
	AST_CHG: assert property (!$past(reset) |-> disk_change_flag ==
		$past((!drive_select0_n && force_change[0]) || !disk_change_in_n
		|| (!drive_select1_n && force_change[1])))
		else $error("disk change wrong");
	AST_WP: assert property (!$past(reset) && $past(!write_protect_n
		|| ((!drive_select0_n || !drive_select1_n) && force_wp_cfg))
		|-> !write_protect_core_n) else $error("write protect missing");
	AST_EN: assert property (!$past(reset)
		|-> (unit_enable & ~$past(unit_activate)) == 5'h00)
		else $error("unit enabled without activate");
	AST_LOCK: assert property (unit_disable_locked ==
		(lock_cfg == 2'b01 && lock_gpio_pin)) else $error("lock wrong");
endmodule : fod_bank_props

// file: verif/fod_drive_model.sv
// model: drive side, step pulses and status pins
`timescale 1ns/1ps
module fod_drive_model (
	input  wire logic sys_clk,
	input  wire logic step_go,
	input  wire logic chg_go,
	input  wire logic wp_go,
	output logic      step_pulse_n,
	output logic      disk_change_in_n,
	output logic      write_protect_n
);
	// pins idle high, as a released drive leaves them
	initial begin
		step_pulse_n = 1'b1;
		disk_change_in_n = 1'b1;
		write_protect_n = 1'b1;
	end
	// requests show one edge later, like a real cable delay
	always @(posedge sys_clk) begin
		step_pulse_n <= !step_go;
		disk_change_in_n <= !chg_go;
		write_protect_n <= !wp_go;
	end
endmodule : fod_drive_model

// file: verif/fod_bank_tb_top.sv
// testbench: register and drive-side checks of the bank
`timescale 1ns/1ps
module fod_bank_tb_top;
	logic        sys_clk, reset, stby, cyc, stb, we, ds0_n, ds1_n, fwp, lpin;
	logic        step_go, chg_go, wp_go, step_n, chg_n, wp_n, dcf, wpc_n, lck;
	logic [1:0]  lcfg, fc;
	logic [9:0]  adr;
	logic [31:0] dat, dat_o;
	logic        ack;
	logic [7:0]  rate, s1, s2;
	logic [4:0]  act, en;
	int          n_mismatch, num_checks;
	fod_bank i_dut (.sys_clk, .reset, .standby_power_on_reset(stby),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(4'h1), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
		.step_pulse_n(step_n), .drive_select0_n(ds0_n),
		.drive_select1_n(ds1_n), .disk_change_in_n(chg_n),
		.write_protect_n(wp_n), .force_wp_cfg(fwp), .lock_cfg(lcfg),
		.lock_gpio_pin(lpin), .floppy_rate_in(rate), .serial_one_fifo_in(s1),
		.serial_two_fifo_in(s2), .unit_activate(act), .unit_enable(en),
		.disk_change_flag(dcf), .write_protect_core_n(wpc_n),
		.force_change(fc), .unit_disable_locked(lck));
	fod_drive_model i_drv (.sys_clk, .step_go, .chg_go, .wp_go,
		.step_pulse_n(step_n), .disk_change_in_n(chg_n),
		.write_protect_n(wp_n));
	//////////////////////////////////////////////////////////////////////
	initial begin
		sys_clk = 1'b0;
		forever #25 sys_clk = !sys_clk;
	end
	task tick(input int n);
		repeat (n) @(posedge sys_clk);
	endtask : tick
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("wrong value %s expected %0h seen %0h", nm, e, g);
		end
	endtask : chk
	// one classic cycle; read data is taken at the ack edge only
	task bus(input logic w, input logic [9:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= {24'h000000, d};
		do @(posedge sys_clk); while (ack !== 1'b1);
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask : bus
	task rd(input logic [9:0] a, input logic [31:0] e);
		bus(1'b0, a, 8'h00);
		chk("read data", e, dat_o);
	endtask : rd
	task step;
		step_go <= 1'b1;
		tick(1);
		step_go <= 1'b0;
		tick(3);
	endtask : step
	task results;
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : results
	//////////////////////////////////////////////////////////////////////
	initial begin
		{reset, stby, ds0_n, ds1_n} = 4'hF;
		{cyc, stb, we, fwp, lpin, step_go, chg_go, wp_go} = 8'h00;
		{lcfg, adr, dat, rate, s1, s2, act} = '0;
		tick(2);
		reset <= 1'b0;
		stby <= 1'b0;
		act <= 5'h1F;
		rd(10'h078, 32'h03);
		bus(1'b1, 10'h088, 8'hFF);
		rd(10'h088, 32'hF9);
		chk("unit_enable", 32'h00, {27'h0, en});
		chk("write protect", 32'h0, {31'h0, wpc_n});
		for (int i = 0; i < 5; i++) begin
			bus(1'b1, 10'h088, 8'h08 << i);
			tick(2);
			chk("unit_enable", {27'h0, 5'h1F & ~(5'h01 << i)}, {27'h0, en});
		end
		// locked register must refuse the write but still ack
		lcfg <= 2'b01;
		lpin <= 1'b1;
		bus(1'b1, 10'h088, 8'h00);
		chk("lock", 32'h1, {31'h0, lck});
		rd(10'h088, 32'h80);
		lpin <= 1'b0;
		bus(1'b1, 10'h088, 8'h00);
		rd(10'h088, 32'h00);
		// any other lock code leaves it writable, even with the pin high
		lcfg <= 2'b11;
		lpin <= 1'b1;
		bus(1'b1, 10'h088, 8'h40);
		chk("lock", 32'h0, {31'h0, lck});
		rd(10'h088, 32'h40);
		{rate, s1, s2} <= 24'hFFFF5A;
		bus(1'b1, 10'h07C, 8'h00);
		rd(10'h07C, 32'hDF);
		rd(10'h080, 32'hCF);
		rd(10'h084, 32'h4A);
		rd(10'h090, 32'h00);
		ds0_n <= 1'b0;
		tick(2);
		chk("disk change", 32'h1, {31'h0, dcf});
		step();
		rd(10'h078, 32'h02);
		chk("force change", 32'h2, {30'h0, fc});
		chk("disk change", 32'h0, {31'h0, dcf});
		bus(1'b1, 10'h078, 8'h00);
		rd(10'h078, 32'h02);
		ds0_n <= 1'b1;
		ds1_n <= 1'b0;
		step();
		rd(10'h078, 32'h00);
		chg_go <= 1'b1;
		tick(3);
		chk("disk change", 32'h1, {31'h0, dcf});
		bus(1'b1, 10'h078, 8'h03);
		rd(10'h078, 32'h03);
		fwp <= 1'b1;
		tick(2);
		chk("write protect", 32'h0, {31'h0, wpc_n});
		fwp <= 1'b0;
		tick(2);
		chk("write protect", 32'h1, {31'h0, wpc_n});
		wp_go <= 1'b1;
		tick(3);
		chk("write protect", 32'h0, {31'h0, wpc_n});
		// main reset alone reloads the flags but keeps unit_disable
		reset <= 1'b1;
		tick(2);
		reset <= 1'b0;
		rd(10'h078, 32'h03);
		rd(10'h088, 32'h40);
		chk("unit_enable", 32'h17, {27'h0, en});
		// only the standby reset clears unit_disable
		stby <= 1'b1;
		tick(1);
		stby <= 1'b0;
		rd(10'h088, 32'h00);
		results();
	end
	// the sequence needs about 120 cycles; a hang is cut short here
	initial begin
		tick(3000);
		n_mismatch++;
		results();
	end
endmodule : fod_bank_tb_top
bind fod_bank fod_bank_props i_props (.sys_clk, .reset, .wb_cyc_i,
	.wb_stb_i, .wb_we_i, .wb_ack_o, .step_pulse_n, .drive_select0_n,
	.drive_select1_n, .disk_change_in_n, .write_protect_n, .force_wp_cfg,
	.lock_cfg, .lock_gpio_pin, .unit_activate, .unit_enable,
	.disk_change_flag, .write_protect_core_n, .force_change,
	.unit_disable_locked);
